// ===== core/adc_seq_defs.svh
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// Register addresses on the processor's special function register bus.
`define ADDR_TEMP_RESULT      8'hD7
`define ADDR_CONV_START       8'hD8
`define ADDR_BATTERY_RESULT   8'hDF
`define ADDR_POWER_IRQ_ENABLE 8'hEC
`define ADDR_CHANGE_DELTA     8'hF3
`define ADDR_POWER_IRQ_FLAGS  8'hF8
`define ADDR_BG_INTERVAL      8'hF9
`define ADDR_LOW_BAT_THR      8'hFA

// Common reset value of every register.
`define REG_RESET 8'h00

// Bit positions inside the start, delta, interval, flag and enable registers.
`define START_BAT_BIT     0
`define START_TEMP_BIT    1
`define DELTA_LSB         3
`define DELTA_MSB         5
`define TEMP_PER_LSB      0
`define TEMP_PER_MSB      1
`define BAT_PER_LSB       2
`define BAT_PER_MSB       3
`define LOW_BAT_FLAG_BIT  0
`define BAT_IRQ_EN_BIT    0

// Delta codes with special meaning.
`define DELTA_NEVER  3'h0
`define DELTA_ALWAYS 3'h7

// Power modes as reported by power management.
`define MODE_FULL    2'h0
`define MODE_BATTERY 2'h1
`define MODE_SLEEP   2'h2

// Background interval codes and their length in minutes.
`define PER_OFF   2'h0
`define PER_CODE1 2'h1
`define PER_CODE2 2'h2
`define PER_CODE3 2'h3
`define TEMP_MIN1 5'h08
`define TEMP_MIN2 5'h02
`define TEMP_MIN3 5'h01
`define BAT_MIN1  5'h10
`define BAT_MIN2  5'h04
`define BAT_MIN3  5'h01
`define MIN_OFF   5'h00

// Timing base: one minute at the system clock rate.
`define MINUTE_S 60
`define CLK_HZ   20000000

`endif

// ===== core/adc_seq_pkg.sv
package adc_seq_pkg;

  // Converter channel sequencing states, one-hot.
  typedef enum logic [2:0] {
    CH_IDLE = 3'b001,
    CH_REQ  = 3'b010,
    CH_WAIT = 3'b100
  } ch_state_t;

  // Answer from one analog converter.
  typedef struct packed {
    logic       ack;
    logic       done;
    logic [7:0] data;
  } conv_rsp_t;

  // One special function register access from the processor.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage

// ===== core/temp_battery_adc_sequencer.sv
// What this block does
// [RULE1] Temperature result: 8-bit read-only, resets zero.
// [RULE2] Temperature start bit runs one conversion, interrupts.
// [RULE3] Background temperature off until interval programmed.
// [RULE4] Background temperature interrupts on delta exceeded.
// [RULE5] Temperature result loads only with interrupt.
// [RULE6] Temperature interrupt has no status flag.
// [RULE7] Full-power mode allows single and background.
// [RULE8] Battery-power mode: temperature single-shot only.
// [RULE9] Sleep mode: temperature background only.
// [RULE10] Battery result: 8-bit read-only register.
// [RULE11] Battery start bit runs one conversion, interrupts.
// [RULE12] Battery background at programmed interval.
// [RULE13] Background battery below threshold sets flag.
// [RULE14] Flag requests interrupt only when enabled.
// [RULE15] Single battery conversion always sets flag.
// [RULE16] Battery result loads only when flag set.
// [RULE17] Battery-power mode: battery single-shot only.
// [RULE18] Sleep mode: battery background only.
// [RULE19] Software runs single temperature before delta, interval.
// [RULE20] Software sets threshold before battery interval.
// [RULE21] Start bit clears when converter accepts request.
// [RULE22] Delta 0 never, 1-6 counts, 7 always.
// [RULE23] Unsigned compares; last interrupting temperature kept.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module adc_channel_ctrl (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  start_set,
  input  wire logic                  single_ok,
  input  wire logic                  bg_ok,
  input  wire logic [4:0]            period_min,
  input  wire logic                  minute_tick,
  input  wire adc_seq_pkg::conv_rsp_t rsp,
  output logic                       conv_req,
  output logic                       start_pending,
  output logic                       done_single,
  output logic                       done_bg,
  output logic [7:0]                 result
);

  adc_seq_pkg::ch_state_t state_r;
  adc_seq_pkg::ch_state_t state_nxt;
  logic       start_r;
  logic       bg_due_r;
  logic       is_bg_r;
  logic [4:0] min_cnt_r;
  logic [4:0] period_last_r;
  logic       done_single_r;
  logic       done_bg_r;
  logic [7:0] result_r;
  logic       bg_fire;
  logic       take_single;
  logic       take_bg;

  // A zero period keeps the background timer parked, so nothing runs after reset.
  assign bg_fire = minute_tick && (period_min != `MIN_OFF) &&
                   (min_cnt_r == period_min - 5'h01); // [RULE3] [RULE12]

  // Single requests win over background so a waiting processor is served first.
  assign take_single = (state_r == adc_seq_pkg::CH_IDLE) && start_r && single_ok; // [RULE9] [RULE18]
  assign take_bg     = (state_r == adc_seq_pkg::CH_IDLE) && bg_due_r && bg_ok && !take_single;

  assign conv_req      = (state_r == adc_seq_pkg::CH_REQ);
  assign start_pending = start_r;
  assign done_single   = done_single_r;
  assign done_bg       = done_bg_r;
  assign result        = result_r;

  // Minute counter restarts whenever software changes the interval.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      min_cnt_r     <= '0;
      period_last_r <= `MIN_OFF;
    end else begin
      period_last_r <= period_min;
      if ((period_min != period_last_r) || (period_min == `MIN_OFF) || bg_fire) begin
        min_cnt_r <= '0;
      end else if (minute_tick) begin
        min_cnt_r <= min_cnt_r + 5'h01;
      end
    end
  end

  // A strobe that falls in a mode without background service is dropped.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bg_due_r <= 1'b0;
    end else if (bg_fire && bg_ok) begin
      bg_due_r <= 1'b1; // [RULE7]
    end else if (take_bg || !bg_ok) begin
      bg_due_r <= 1'b0; // [RULE8] [RULE17]
    end
  end

  // Start bit: a new write in the cycle of the acceptance keeps it set.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_r <= 1'b0;
    end else if (start_set) begin
      start_r <= 1'b1;
    end else if (conv_req && rsp.ack && !is_bg_r) begin
      start_r <= 1'b0; // [RULE21]
    end
  end

  // Request, acceptance and completion sequencing.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      adc_seq_pkg::CH_IDLE: begin
        if (take_single || take_bg) begin
          state_nxt = adc_seq_pkg::CH_REQ;
        end
      end
      adc_seq_pkg::CH_REQ: begin
        if (rsp.ack) begin
          state_nxt = adc_seq_pkg::CH_WAIT;
        end
      end
      adc_seq_pkg::CH_WAIT: begin
        if (rsp.done) begin
          state_nxt = adc_seq_pkg::CH_IDLE;
        end
      end
      default: begin
        state_nxt = adc_seq_pkg::CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= adc_seq_pkg::CH_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Remember the source of the running conversion.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      is_bg_r <= 1'b0;
    end else if (take_single || take_bg) begin
      is_bg_r <= take_bg;
    end
  end

  // Completion pulses with the captured result, one cycle each.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_single_r <= 1'b0;
      done_bg_r     <= 1'b0;
      result_r      <= `REG_RESET;
    end else begin
      done_single_r <= (state_r == adc_seq_pkg::CH_WAIT) && rsp.done && !is_bg_r;
      done_bg_r     <= (state_r == adc_seq_pkg::CH_WAIT) && rsp.done && is_bg_r;
      if ((state_r == adc_seq_pkg::CH_WAIT) && rsp.done) begin
        result_r <= rsp.data;
      end
    end
  end

  sequence accept_single_s;
    conv_req && rsp.ack && !is_bg_r && !start_set;
  endsequence

  start_self_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE21]
    accept_single_s |=> !start_r)
    else $error("start bit not cleared after acceptance");

  // The mode is judged in the cycle the request is taken, so a later mode change cannot trip these.
  bg_mode_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8] [RULE17]
    $rose(conv_req) && is_bg_r |-> $past(bg_ok))
    else $error("background conversion started in a single-only mode");

  single_mode_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE9] [RULE18]
    $rose(conv_req) && !is_bg_r |-> $past(single_ok))
    else $error("single conversion started in a background-only mode");

  bg_off_idle_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
    $rose(bg_due_r) |-> $past(period_min != `MIN_OFF))
    else $error("background strobe with interval off");

endmodule // adc_channel_ctrl

module temp_battery_adc_sequencer #(
  parameter int unsigned MINUTE_CYCLES = `MINUTE_S * `CLK_HZ
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire adc_seq_pkg::sfr_req_t  sfr,
  output logic [7:0]                  sfr_rdata,
  input  wire logic [1:0]             power_mode,
  output logic                        temp_conv_req,
  input  wire adc_seq_pkg::conv_rsp_t temp_rsp,
  output logic                        bat_conv_req,
  input  wire adc_seq_pkg::conv_rsp_t bat_rsp,
  output logic                        temp_irq,
  output logic                        power_irq
);

  logic [30:0] tick_cnt_r;
  logic        minute_tick;
  logic [2:0]  delta_r;
  logic [3:0]  interval_r;
  logic [7:0]  thr_r;
  logic        bat_en_r;
  logic        low_bat_flag_r;
  logic [7:0]  temp_result_r;
  logic [7:0]  battery_result_r;
  logic [7:0]  last_temp_r;
  logic        temp_irq_r;
  logic [7:0]  rdata_r;
  logic        single_ok;
  logic        bg_ok;
  logic        t_pend;
  logic        t_done_s;
  logic        t_done_b;
  logic [7:0]  t_res;
  logic        b_pend;
  logic        b_done_s;
  logic        b_done_b;
  logic [7:0]  b_res;
  logic [7:0]  temperature_delta_field;
  logic        diff_hit;
  logic        temp_fire;
  logic        bat_set;
  logic        wr_start;

  // Interval codes to minutes.
  function automatic logic [4:0] temp_minutes(input logic [1:0] code);
    case (code)
      `PER_CODE1: temp_minutes = `TEMP_MIN1;
      `PER_CODE2: temp_minutes = `TEMP_MIN2;
      `PER_CODE3: temp_minutes = `TEMP_MIN3;
      default:    temp_minutes = `MIN_OFF;
    endcase
  endfunction

  function automatic logic [4:0] bat_minutes(input logic [1:0] code);
    case (code)
      `PER_CODE1: bat_minutes = `BAT_MIN1;
      `PER_CODE2: bat_minutes = `BAT_MIN2;
      `PER_CODE3: bat_minutes = `BAT_MIN3;
      default:    bat_minutes = `MIN_OFF;
    endcase
  endfunction

  // Mode gating: with the processor halted nobody can ask for a single shot.
  assign single_ok = (power_mode == `MODE_FULL) || (power_mode == `MODE_BATTERY); // [RULE7]
  assign bg_ok     = (power_mode == `MODE_FULL) || (power_mode == `MODE_SLEEP); // [RULE9]
  assign wr_start  = sfr.wr && (sfr.addr == `ADDR_CONV_START);

  // Shared minute base; a full minute is long, so simulations shorten the parameter.
  assign minute_tick = (tick_cnt_r == 31'(MINUTE_CYCLES - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (minute_tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 31'h1;
    end
  end

  adc_channel_ctrl temp_ch (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .start_set     (wr_start && sfr.wdata[`START_TEMP_BIT]), // [RULE2]
    .single_ok     (single_ok),
    .bg_ok         (bg_ok),
    .period_min    (temp_minutes(interval_r[`TEMP_PER_MSB:`TEMP_PER_LSB])),
    .minute_tick   (minute_tick),
    .rsp           (temp_rsp),
    .conv_req      (temp_conv_req),
    .start_pending (t_pend),
    .done_single   (t_done_s),
    .done_bg       (t_done_b),
    .result        (t_res)
  );

  adc_channel_ctrl bat_ch (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .start_set     (wr_start && sfr.wdata[`START_BAT_BIT]), // [RULE11]
    .single_ok     (single_ok),
    .bg_ok         (bg_ok),
    .period_min    (bat_minutes(interval_r[`BAT_PER_MSB:`BAT_PER_LSB])), // [RULE12]
    .minute_tick   (minute_tick),
    .rsp           (bat_rsp),
    .conv_req      (bat_conv_req),
    .start_pending (b_pend),
    .done_single   (b_done_s),
    .done_bg       (b_done_b),
    .result        (b_res)
  );

  // Unsigned distance from the last value that interrupted.
  assign temperature_delta_field = (t_res >= last_temp_r) ? (t_res - last_temp_r)
                                            : (last_temp_r - t_res); // [RULE23]
  assign diff_hit  = (delta_r == `DELTA_ALWAYS) ||
                     ((delta_r != `DELTA_NEVER) && (temperature_delta_field > {5'h00, delta_r})); // [RULE22] [RULE4]
  assign temp_fire = t_done_s || (t_done_b && diff_hit); // [RULE2] [RULE4]

  // The interrupt is a bare pulse; no flag records it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      temp_irq_r    <= 1'b0;
      temp_result_r <= `REG_RESET; // [RULE1]
      last_temp_r   <= `REG_RESET;
    end else begin
      temp_irq_r <= temp_fire; // [RULE6]
      if (temp_fire) begin
        temp_result_r <= t_res; // [RULE5]
        last_temp_r   <= t_res; // [RULE23]
      end
    end
  end

  assign temp_irq = temp_irq_r;

  // Battery event: single shots always flag, background only below threshold.
  assign bat_set = b_done_s || (b_done_b && (b_res < thr_r)); // [RULE13] [RULE15] [RULE23]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      battery_result_r <= `REG_RESET; // [RULE10]
    end else if (bat_set) begin
      battery_result_r <= b_res; // [RULE16]
    end
  end

  // Flag: a hardware set wins over a software write in the same cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_bat_flag_r <= 1'b0;
    end else if (bat_set) begin
      low_bat_flag_r <= 1'b1; // [RULE13] [RULE15]
    end else if (sfr.wr && (sfr.addr == `ADDR_POWER_IRQ_FLAGS)) begin
      low_bat_flag_r <= sfr.wdata[`LOW_BAT_FLAG_BIT];
    end
  end

  assign power_irq = low_bat_flag_r && bat_en_r; // [RULE14]

  // Writable configuration; results are read-only and ignore writes.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      delta_r    <= '0;
      interval_r <= '0; // [RULE3]
      thr_r      <= `REG_RESET;
      bat_en_r   <= 1'b0;
    end else if (sfr.wr) begin
      case (sfr.addr)
        `ADDR_CHANGE_DELTA:     delta_r    <= sfr.wdata[`DELTA_MSB:`DELTA_LSB];
        `ADDR_BG_INTERVAL:      interval_r <= sfr.wdata[`BAT_PER_MSB:`TEMP_PER_LSB];
        `ADDR_LOW_BAT_THR:      thr_r      <= sfr.wdata;
        `ADDR_POWER_IRQ_ENABLE: bat_en_r   <= sfr.wdata[`BAT_IRQ_EN_BIT];
        default: begin
        end
      endcase
    end
  end

  // Registered read; unmapped addresses and reserved bits answer zero.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `REG_RESET;
    end else if (sfr.rd) begin
      rdata_r <= `REG_RESET;
      case (sfr.addr)
        `ADDR_TEMP_RESULT:      rdata_r <= temp_result_r;
        `ADDR_BATTERY_RESULT:   rdata_r <= battery_result_r;
        `ADDR_CONV_START: begin
          rdata_r[`START_TEMP_BIT] <= t_pend;
          rdata_r[`START_BAT_BIT]  <= b_pend;
        end
        `ADDR_CHANGE_DELTA:     rdata_r[`DELTA_MSB:`DELTA_LSB] <= delta_r;
        `ADDR_BG_INTERVAL:      rdata_r[`BAT_PER_MSB:`TEMP_PER_LSB] <= interval_r;
        `ADDR_LOW_BAT_THR:      rdata_r <= thr_r;
        `ADDR_POWER_IRQ_ENABLE: rdata_r[`BAT_IRQ_EN_BIT] <= bat_en_r;
        `ADDR_POWER_IRQ_FLAGS:  rdata_r[`LOW_BAT_FLAG_BIT] <= low_bat_flag_r;
        default: begin
        end
      endcase
    end
  end

  assign sfr_rdata = rdata_r;

  sequence temp_single_done_s;
    t_done_s;
  endsequence

  temp_single_irq_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
    temp_single_done_s |=> temp_irq_r && (temp_result_r == $past(t_res)))
    else $error("single temperature conversion did not interrupt");

  temp_load_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
    !$stable(temp_result_r) |-> temp_irq_r)
    else $error("temperature result changed without interrupt");

  delta_never_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE22]
    t_done_b && !t_done_s && (delta_r == `DELTA_NEVER) |=> !temp_irq_r)
    else $error("background interrupt with delta code zero");

  delta_exceed_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
    t_done_b && (delta_r != `DELTA_NEVER) && (delta_r != `DELTA_ALWAYS) &&
    (temperature_delta_field > {5'h00, delta_r}) |=> temp_irq_r ##1 (last_temp_r == $past(t_res, 2)))
    else $error("delta exceeded without interrupt");

  bat_single_flag_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE15]
    b_done_s |=> low_bat_flag_r && (battery_result_r == $past(b_res)))
    else $error("single battery conversion did not set flag");

  bat_low_flag_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE13]
    b_done_b && (b_res < thr_r) |=> low_bat_flag_r)
    else $error("low background battery did not set flag");

  bat_load_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE16]
    b_done_b && (b_res >= thr_r) |=> $stable(battery_result_r))
    else $error("battery result changed above threshold");

  power_irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE14]
    bat_set |=> low_bat_flag_r && (power_irq == bat_en_r))
    else $error("power interrupt does not follow its enable");

endmodule // temp_battery_adc_sequencer

// ===== verif/adc_conv_model.sv
`timescale 1ns/1ps

// Behavioural converter: it accepts a request ACK_DLY cycles after seeing
// it and finishes DONE_DLY+1 cycles after accepting.
module adc_conv_model #(
  parameter int ACK_DLY  = 0,
  parameter int DONE_DLY = 3
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              req,
  input  wire logic [7:0]        data_in,
  output adc_seq_pkg::conv_rsp_t rsp
);
  int         cnt;
  logic       busy;
  logic [7:0] last;

  // One conversion at a time. Outside the done cycle the data lines show
  // the inverse of the last result, so a stale sample cannot pass.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 0;
      busy <= 1'h0;
      last <= 8'h00;
      rsp  <= '0;
    end else begin
      rsp.ack  <= 1'h0;
      rsp.done <= 1'h0;
      rsp.data <= ~last;
      if (busy) begin
        cnt <= cnt + 1;
        if (cnt == DONE_DLY) begin
          rsp.done <= 1'h1;
          rsp.data <= data_in;
          last     <= data_in;
          busy     <= 1'h0;
          cnt      <= 0;
        end
      end else if (req && !rsp.ack) begin
        cnt <= cnt + 1;
        if (cnt == ACK_DLY) begin
          rsp.ack <= 1'h1;
          busy    <= 1'h1;
          cnt     <= 0;
        end
      end
    end
  end
endmodule // adc_conv_model

// ===== verif/temp_battery_adc_sequencer_test.sv
`timescale 1ns/1ps

module temp_battery_adc_sequencer_test;
  localparam int MIN_CYC = 20;
  localparam int WIN     = 3 * MIN_CYC;

  logic                   mclk;
  logic                   rst_n;
  adc_seq_pkg::sfr_req_t  sfr;
  logic [7:0]             sfr_rdata;
  logic [1:0]             power_mode;
  logic                   temp_conv_req;
  logic                   bat_conv_req;
  logic                   temp_irq;
  logic                   power_irq;
  adc_seq_pkg::conv_rsp_t temp_rsp;
  adc_seq_pkg::conv_rsp_t bat_rsp;
  logic [7:0]             temp_val;
  logic [7:0]             bat_val;
  int                     n_mismatch;
  int                     n_tests;

  // A short minute keeps the background intervals within a brief run.
  temp_battery_adc_sequencer #(.MINUTE_CYCLES(MIN_CYC)) DUT (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .sfr           (sfr),
    .sfr_rdata     (sfr_rdata),
    .power_mode    (power_mode),
    .temp_conv_req (temp_conv_req),
    .temp_rsp      (temp_rsp),
    .bat_conv_req  (bat_conv_req),
    .bat_rsp       (bat_rsp),
    .temp_irq      (temp_irq),
    .power_irq     (power_irq)
  );

  // The temperature converter accepts slowly, the battery one finishes slowly.
  adc_conv_model #(.ACK_DLY(3), .DONE_DLY(4)) temp_conv (
    .mclk(mclk), .rst_n(rst_n), .req(temp_conv_req), .data_in(temp_val), .rsp(temp_rsp)
  );
  adc_conv_model #(.ACK_DLY(1), .DONE_DLY(6)) bat_conv (
    .mclk(mclk), .rst_n(rst_n), .req(bat_conv_req), .data_in(bat_val), .rsp(bat_rsp)
  );

  // Clock at 20 MHz.
  always #25 mclk = ~mclk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr <= {1'h1, 1'h0, a, d};
    @(posedge mclk);
    sfr <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    sfr <= {1'h0, 1'h1, a, 8'h00};
    @(posedge mclk);
    sfr <= '0;
    #1;
    chk(sfr_rdata, e);
  endtask

  // Watches one output for up to n cycles; a missing expected event ends the run.
  task automatic waitfor(input int sel, input int n, input logic exp);
    logic s;
    logic got;
    got = 1'h0;
    for (int i = 0; i < n && !got; i++) begin
      @(posedge mclk);
      #1;
      s = (sel == 0) ? temp_irq : (sel == 1) ? power_irq :
          (sel == 2) ? temp_conv_req : bat_conv_req;
      if (s === 1'h1) got = 1'h1;
    end
    chk({7'h00, got}, {7'h00, exp});
    if (exp && !got) final_report();
  endtask

  task automatic s_reset();
    logic [7:0] addrs [9];
    addrs = '{8'hD7, 8'hD8, 8'hDF, 8'hEC, 8'hF3, 8'hF8, 8'hF9, 8'hFA, 8'h10};
    foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
    wr(8'hD7, 8'hA5);
    wr(8'hDF, 8'h5A);
    rd_chk(8'hD7, 8'h00);
    rd_chk(8'hDF, 8'h00);
    waitfor(2, WIN, 1'h0);
  endtask

  task automatic s_one_temp();
    temp_val = 8'h40;
    wr(8'hD8, 8'h02);
    rd_chk(8'hD8, 8'h02);
    waitfor(0, 40, 1'h1);
    rd_chk(8'hD7, 8'h40);
    rd_chk(8'hD8, 8'h00);
    rd_chk(8'hF8, 8'h00);
  endtask

  task automatic s_one_bat();
    bat_val = 8'h55;
    wr(8'hEC, 8'h01);
    wr(8'hD8, 8'h01);
    waitfor(1, 40, 1'h1);
    rd_chk(8'hDF, 8'h55);
    rd_chk(8'hF8, 8'h01);
    wr(8'hEC, 8'h00);
    #1;
    chk({7'h00, power_irq}, 8'h00);
    wr(8'hF8, 8'h00);
    wr(8'hEC, 8'h01);
    #1;
    chk({7'h00, power_irq}, 8'h00);
  endtask

  // Delta is written before the new value, so no conversion sees a mixed pair.
  task automatic s_bg_temp();
    logic [7:0] tab [6][3];
    logic [7:0] res;
    tab = '{'{8'h02, 8'h42, 8'h00}, '{8'h02, 8'h3D, 8'h01}, '{8'h02, 8'h40, 8'h01},
            '{8'h02, 8'h3E, 8'h00}, '{8'h00, 8'hF0, 8'h00}, '{8'h07, 8'hF0, 8'h01}};
    res = 8'h40;
    wr(8'hF3, 8'h10);
    wr(8'hF9, 8'h03);
    rd_chk(8'hF3, 8'h10);
    rd_chk(8'hF9, 8'h03);
    foreach (tab[i]) begin
      wr(8'hF3, tab[i][0] << 3);
      temp_val <= tab[i][1];
      waitfor(0, WIN, tab[i][2][0]);
      if (tab[i][2][0]) res = tab[i][1];
      rd_chk(8'hD7, res);
    end
  endtask

  task automatic s_modes();
    @(posedge mclk) power_mode <= 2'h1;
    wr(8'hF9, 8'h0F);
    repeat (20) @(posedge mclk);
    waitfor(2, WIN, 1'h0);
    waitfor(3, WIN, 1'h0);
    temp_val = 8'h11;
    wr(8'hD8, 8'h02);
    waitfor(0, 40, 1'h1);
    rd_chk(8'hD7, 8'h11);
    @(posedge mclk) power_mode <= 2'h2;
    wr(8'hF9, 8'h00);
    repeat (20) @(posedge mclk);
    wr(8'hD8, 8'h03);
    waitfor(2, WIN, 1'h0);
    waitfor(3, WIN, 1'h0);
    wr(8'hF9, 8'h0F);
    waitfor(2, WIN, 1'h1);
    waitfor(3, WIN, 1'h1);
    wr(8'hF9, 8'h00);
    @(posedge mclk) power_mode <= 2'h0;
    repeat (40) @(posedge mclk);
  endtask

  // Threshold goes in before the interval; a value equal to it is not low.
  task automatic s_bg_bat();
    wr(8'hF8, 8'h00);
    wr(8'hFA, 8'h80);
    rd_chk(8'hFA, 8'h80);
    bat_val <= 8'h80;
    wr(8'hF9, 8'h0C);
    waitfor(3, WIN, 1'h1);
    repeat (WIN) @(posedge mclk);
    rd_chk(8'hF8, 8'h00);
    rd_chk(8'hDF, 8'h55);
    bat_val = 8'h7F;
    waitfor(1, WIN, 1'h1);
    rd_chk(8'hDF, 8'h7F);
  endtask

  // The gap between two background requests must equal the programmed interval.
  task automatic s_period(input logic [7:0] code, input int sel, input int exp_cyc);
    logic s;
    int   cyc;
    cyc = 0;
    wr(8'hF9, 8'h00);
    repeat (MIN_CYC) @(posedge mclk);
    wr(8'hF9, code);
    waitfor(sel, 2 * exp_cyc, 1'h1);
    for (int i = 1; i <= 2 * exp_cyc && cyc == 0; i++) begin
      @(posedge mclk);
      #1;
      s = (sel == 2) ? temp_conv_req : bat_conv_req;
      if (s === 1'h1 && i > 10) cyc = i;
    end
    chk({7'h00, cyc == exp_cyc}, 8'h01);
    if (cyc == 0) final_report();
  endtask

  task automatic s_rereset();
    @(posedge mclk) rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    rd_chk(8'hD7, 8'h00);
    rd_chk(8'hF9, 8'h00);
  endtask

  // Main sequence; the settings of each scenario carry into the next.
  initial begin
    mclk       = 1'h0;
    rst_n      = 1'h0;
    sfr        = '0;
    power_mode = 2'h0;
    temp_val   = 8'h00;
    bat_val    = 8'h00;
    n_mismatch = 0;
    n_tests    = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    s_reset();
    s_one_temp();
    s_one_bat();
    s_bg_temp();
    s_modes();
    s_bg_bat();
    s_period(8'h02, 2, 2 * MIN_CYC);
    s_period(8'h01, 2, 8 * MIN_CYC);
    s_period(8'h08, 3, 4 * MIN_CYC);
    s_period(8'h04, 3, 16 * MIN_CYC);
    s_rereset();
    final_report();
  end

  // Guards against a hang that the bounded waits cannot see.
  initial begin
    #1000000;
    n_mismatch++;
    final_report();
  end
endmodule // temp_battery_adc_sequencer_test
